// file: common/t8wg_cfg.svh
`ifndef T8WG_CFG_SVH
`define T8WG_CFG_SVH

// Register byte offsets on the APB slave.
`define T8WG_OFF_CTRL 12'h000
`define T8WG_OFF_CMP 12'h004
`define T8WG_OFF_CNT 12'h008
`define T8WG_OFF_FLAG 12'h00C
`define T8WG_OFF_PIN 12'h010

// Control register fields.
`define T8WG_CTRL_WGM_LSB 0
`define T8WG_CTRL_WGM_MSB 1
`define T8WG_CTRL_COM_LSB 2
`define T8WG_CTRL_COM_MSB 3
`define T8WG_CTRL_FORCE_BIT 7

// Flag register fields, write one to clear.
`define T8WG_FLAG_OVF_BIT 0
`define T8WG_FLAG_CMP_BIT 1

// Pin register fields.
`define T8WG_PIN_DATA_BIT 0
`define T8WG_PIN_DIR_BIT 1
`define T8WG_PIN_IN_BIT 2

// Count extremes and reset values.
`define T8WG_CNT_MAX 8'hFF
`define T8WG_CNT_BOTTOM 8'h00
`define T8WG_RST_BYTE 8'h00
`define T8WG_RST_WORD 32'h0000_0000
`define T8WG_CNT_STEP 8'h01

// Compare output mode encodings.
`define T8WG_COM_OFF 2'h0
`define T8WG_COM_TOGGLE 2'h1
`define T8WG_COM_CLEAR 2'h2
`define T8WG_COM_SET 2'h3

`endif

// file: common/t8wg_pkg.sv
package t8wg_pkg;

  // Encoding order follows the waveform mode field values 0 to 3.
  typedef enum logic [1:0] {
    T8WG_NORMAL,
    T8WG_PHASE,
    T8WG_CLEAR_CMP,
    T8WG_FAST
  } t8wg_wave_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic [7:0] ocr_buf;
    t8wg_wave_t wgm;
    logic [1:0] com;
    logic oc;
    logic ovf;
    logic cmpf;
    logic blk;
    logic port_data;
    logic dir;
    logic [31:0] rdata;
    logic slverr;
  } t8wg_state_t;

endpackage

// file: src/t8wg_top.sv
`timescale 1ns/1ps
`include "t8wg_cfg.svh"
module t8wg_top (
  input wire logic REF_CLK, // 10 MHz I/O clock
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction, high for write
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [3:0] PSTRB, // APB byte strobes
  output logic PREADY, // APB ready
  output logic [31:0] PRDATA, // APB read data
  output logic PSLVERR, // APB error on unmapped address
  input wire logic TIMER_CLK_EN, // one-cycle timer clock enable
  input wire logic OVF_ACK, // overflow interrupt serviced
  input wire logic CMP_ACK, // compare interrupt serviced
  input wire logic PIN_I, // level seen on the port pin
  output logic PIN_O, // value driven on the port pin
  output logic PIN_OE, // pin driver enable, high drives
  output logic OC_STATE, // compare output state
  output logic OVF_FLAG, // overflow flag level
  output logic CMP_FLAG // compare flag level
);

  t8wg_pkg::t8wg_state_t s_r;
  t8wg_pkg::t8wg_state_t s_nxt;

  logic setup;
  logic wr;
  logic lane0;
  logic ctrl_wr;
  logic cmp_wr;
  logic cnt_wr;
  logic flag_wr;
  logic pin_wr;
  logic pwm;
  logic hit;
  logic at_max;
  logic force_now;
  t8wg_pkg::t8wg_wave_t new_wgm;
  logic [1:0] new_com;

  function automatic logic com_action(input logic [1:0] com,
                                      input logic cur);
    logic res;
    res = cur;
    case (com)
      `T8WG_COM_TOGGLE: res = ~cur;
      `T8WG_COM_CLEAR: res = 1'b0;
      `T8WG_COM_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE;
  assign lane0 = PSTRB[0];
  assign ctrl_wr = wr & lane0 & (PADDR == `T8WG_OFF_CTRL);
  assign cmp_wr = wr & lane0 & (PADDR == `T8WG_OFF_CMP);
  assign cnt_wr = wr & lane0 & (PADDR == `T8WG_OFF_CNT);
  assign flag_wr = wr & lane0 & (PADDR == `T8WG_OFF_FLAG);
  assign pin_wr = wr & lane0 & (PADDR == `T8WG_OFF_PIN);
  assign new_wgm = t8wg_pkg::t8wg_wave_t'(
    PWDATA[`T8WG_CTRL_WGM_MSB:`T8WG_CTRL_WGM_LSB]);
  assign new_com = PWDATA[`T8WG_CTRL_COM_MSB:`T8WG_CTRL_COM_LSB];
  // Phase-correct counting is not built; that code only keeps buffering and blocks the force strobe.
  assign pwm = (s_r.wgm == t8wg_pkg::T8WG_FAST) |
               (s_r.wgm == t8wg_pkg::T8WG_PHASE);
  // A count write in this cycle blocks the match as well as the next tick.
  assign hit = (s_r.cnt == s_r.ocr) & ~s_r.blk & ~cnt_wr;
  assign at_max = (s_r.cnt == `T8WG_CNT_MAX);
  assign force_now = ctrl_wr & PWDATA[`T8WG_CTRL_FORCE_BIT] &
                     (new_wgm != t8wg_pkg::T8WG_FAST) &
                     (new_wgm != t8wg_pkg::T8WG_PHASE);

  always_comb begin
    s_nxt = s_r;

    // Clears come first so that a hardware set in the same cycle wins.
    if ((flag_wr & PWDATA[`T8WG_FLAG_OVF_BIT]) | OVF_ACK) begin
      s_nxt.ovf = 1'b0;
    end
    if ((flag_wr & PWDATA[`T8WG_FLAG_CMP_BIT]) | CMP_ACK) begin
      s_nxt.cmpf = 1'b0;
    end

    if (TIMER_CLK_EN) begin
      s_nxt.blk = 1'b0;
      if (hit) begin
        s_nxt.cmpf = 1'b1;
      end
      if (at_max) begin
        s_nxt.ovf = 1'b1;
      end
      if ((s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) && hit) begin
        s_nxt.cnt = `T8WG_CNT_BOTTOM;
      end else begin
        // Eight-bit sum wraps max to bottom in every mode.
        s_nxt.cnt = s_r.cnt + `T8WG_CNT_STEP;
      end
      if (pwm && at_max) begin
        s_nxt.ocr = s_r.ocr_buf;
      end
      if (s_r.wgm == t8wg_pkg::T8WG_FAST) begin
        // Bottom action is applied after the match so it wins at max.
        if (hit) begin
          s_nxt.oc = com_action(s_r.com, s_r.oc);
        end
        if (at_max && s_r.com[1]) begin
          s_nxt.oc = ~s_r.com[0];
        end
      end else if (hit) begin
        s_nxt.oc = com_action(s_r.com, s_r.oc);
      end
    end

    if (ctrl_wr) begin
      s_nxt.wgm = new_wgm;
      s_nxt.com = new_com;
    end
    if (force_now) begin
      // Uses the output mode written together with the strobe.
      s_nxt.oc = com_action(new_com, s_nxt.oc);
    end
    if (cmp_wr) begin
      s_nxt.ocr_buf = PWDATA[7:0];
      if (!pwm) begin
        s_nxt.ocr = PWDATA[7:0];
      end
    end
    if (cnt_wr) begin
      s_nxt.cnt = PWDATA[7:0];
      s_nxt.blk = 1'b1;
    end
    if (pin_wr) begin
      s_nxt.port_data = PWDATA[`T8WG_PIN_DATA_BIT];
      s_nxt.dir = PWDATA[`T8WG_PIN_DIR_BIT];
    end

    // Read data is captured in the setup cycle so PRDATA is a register.
    if (setup) begin
      s_nxt.rdata = `T8WG_RST_WORD;
      s_nxt.slverr = 1'b0;
      case (PADDR)
        `T8WG_OFF_CTRL: begin
          s_nxt.rdata[`T8WG_CTRL_WGM_MSB:`T8WG_CTRL_WGM_LSB] = s_r.wgm;
          s_nxt.rdata[`T8WG_CTRL_COM_MSB:`T8WG_CTRL_COM_LSB] = s_r.com;
        end
        `T8WG_OFF_CMP: begin
          s_nxt.rdata[7:0] = s_r.ocr_buf;
        end
        `T8WG_OFF_CNT: begin
          s_nxt.rdata[7:0] = s_r.cnt;
        end
        `T8WG_OFF_FLAG: begin
          s_nxt.rdata[`T8WG_FLAG_OVF_BIT] = s_r.ovf;
          s_nxt.rdata[`T8WG_FLAG_CMP_BIT] = s_r.cmpf;
        end
        `T8WG_OFF_PIN: begin
          s_nxt.rdata[`T8WG_PIN_DATA_BIT] = s_r.port_data;
          s_nxt.rdata[`T8WG_PIN_DIR_BIT] = s_r.dir;
          s_nxt.rdata[`T8WG_PIN_IN_BIT] = PIN_I;
        end
        default: begin
          s_nxt.slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_r.cnt <= `T8WG_RST_BYTE;
      s_r.ocr <= `T8WG_RST_BYTE;
      s_r.ocr_buf <= `T8WG_RST_BYTE;
      s_r.wgm <= t8wg_pkg::T8WG_NORMAL;
      s_r.com <= `T8WG_COM_OFF;
      s_r.oc <= 1'b0;
      s_r.ovf <= 1'b0;
      s_r.cmpf <= 1'b0;
      s_r.blk <= 1'b0;
      s_r.port_data <= 1'b0;
      s_r.dir <= 1'b0;
      s_r.rdata <= `T8WG_RST_WORD;
      s_r.slverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PREADY = PSEL & PENABLE;
  assign PRDATA = s_r.rdata;
  assign PSLVERR = PSEL & PENABLE & s_r.slverr;
  // Override follows the output mode alone, never the waveform mode.
  assign PIN_O = (s_r.com != `T8WG_COM_OFF) ? s_r.oc : s_r.port_data;
  assign PIN_OE = s_r.dir;
  assign OC_STATE = s_r.oc;
  assign OVF_FLAG = s_r.ovf;
  assign CMP_FLAG = s_r.cmpf;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  chk_com_zero_hold: assert property (
    (s_r.com == `T8WG_COM_OFF) && !ctrl_wr |=> $stable(s_r.oc))
    else $error("output state moved with output mode zero");

  chk_pin_override: assert property (
    (s_r.com != `T8WG_COM_OFF) && !pin_wr |=>
      (s_r.com == `T8WG_COM_OFF) || (PIN_O == s_r.oc))
    else $error("pin value not taken from output state");

  chk_pin_direction: assert property (
    pin_wr && !PWDATA[`T8WG_PIN_DIR_BIT] |=> !PIN_OE)
    else $error("pin driven while direction is input");

  chk_reset_clears: assert property (disable iff (1'b0)
    SYS_RST |=> !OC_STATE && !OVF_FLAG && (s_r.cnt == `T8WG_CNT_BOTTOM))
    else $error("reset left state set");

  chk_normal_wrap: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_NORMAL) && at_max &&
      !cnt_wr |=> (s_r.cnt == `T8WG_CNT_BOTTOM) && OVF_FLAG)
    else $error("normal mode did not wrap with overflow");

  chk_match_clear: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) && hit && !cnt_wr
      |=> (s_r.cnt == `T8WG_CNT_BOTTOM) && CMP_FLAG)
    else $error("match did not clear count and set flag");

  chk_match_flag: assert property (
    !TIMER_CLK_EN && !s_r.cmpf && !cnt_wr ##1 TIMER_CLK_EN && hit
      |=> CMP_FLAG)
    else $error("compare flag not set on tick after match");

  chk_count_block: assert property (
    cnt_wr ##1 (TIMER_CLK_EN && !s_r.cmpf) |=> !s_r.cmpf)
    else $error("match not blocked after count write");

  chk_fast_bottom: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && at_max &&
      (s_r.com == `T8WG_COM_CLEAR) && !ctrl_wr |=> OC_STATE ##1 1'b1)
    else $error("fast PWM bottom did not set output");

  chk_pwm_buffer: assert property (
    (s_r.wgm == t8wg_pkg::T8WG_FAST) && cmp_wr && !ctrl_wr &&
      !(TIMER_CLK_EN && at_max) |=> (s_r.ocr == $past(s_r.ocr)))
    else $error("active compare changed outside bottom");

  chk_force_quiet: assert property (
    force_now && !TIMER_CLK_EN && !s_r.cmpf |=>
      !s_r.cmpf && (s_r.cnt == $past(s_r.cnt)))
    else $error("force changed flag or count");

  chk_tick_only: assert property (
    !TIMER_CLK_EN && !cnt_wr |=> (s_r.cnt == $past(s_r.cnt)))
    else $error("count moved without timer enable");

  chk_set_wins: assert property (
    TIMER_CLK_EN && at_max && OVF_ACK |=> OVF_FLAG)
    else $error("overflow lost to clear");

  chk_override_off: assert property (
    (s_r.com == `T8WG_COM_OFF) |-> (PIN_O == s_r.port_data))
    else $error("port data not on pin with output mode zero");

  chk_count_write: assert property (
    cnt_wr |=> (s_r.cnt == $past(PWDATA[7:0])))
    else $error("count write not taken");

  chk_normal_noclear: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_NORMAL) && hit &&
      !at_max && !cnt_wr |=> (s_r.cnt == $past(s_r.cnt) + `T8WG_CNT_STEP))
    else $error("normal mode count cleared by match");

  // A compare value written below the count must not stop the count.
  chk_miss_runs: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) &&
      (s_r.cnt > s_r.ocr) && !at_max && !cnt_wr
      |=> (s_r.cnt == $past(s_r.cnt) + `T8WG_CNT_STEP))
    else $error("count did not run on past missed match");

  chk_top_flag: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) && hit
      |=> CMP_FLAG)
    else $error("top match did not set compare flag");

  chk_toggle_match: assert property (
    TIMER_CLK_EN && !pwm && hit && (s_r.com == `T8WG_COM_TOGGLE) &&
      !ctrl_wr |=> (OC_STATE != $past(OC_STATE)))
    else $error("output state did not toggle on match");

  chk_top_overflow: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) && at_max
      |=> OVF_FLAG)
    else $error("overflow not set when passing max");

  chk_fast_restart: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && at_max &&
      !cnt_wr |=> (s_r.cnt == `T8WG_CNT_BOTTOM))
    else $error("fast PWM count did not restart at bottom");

  chk_fast_overflow: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && at_max
      |=> OVF_FLAG)
    else $error("fast PWM overflow not set at max");

  chk_fast_match: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && hit && !at_max &&
      (s_r.com == `T8WG_COM_CLEAR) && !ctrl_wr |=> !OC_STATE)
    else $error("fast PWM match did not clear output");

  chk_spike_rise: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && at_max &&
      (s_r.ocr == `T8WG_CNT_BOTTOM) && (s_r.com == `T8WG_COM_CLEAR) &&
      !ctrl_wr |=> OC_STATE)
    else $error("fast PWM spike did not rise at bottom");

  // With compare at max the bottom action must beat the match.
  chk_constant_high: assert property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_FAST) && hit && at_max &&
      (s_r.com == `T8WG_COM_CLEAR) && !ctrl_wr |=> OC_STATE)
    else $error("fast PWM output not held at max compare");

  chk_mode_later: assert property (
    ctrl_wr && !force_now && !TIMER_CLK_EN |=> $stable(OC_STATE))
    else $error("new output mode acted before a match");

  chk_force_apply: assert property (
    force_now && !TIMER_CLK_EN && (new_com == `T8WG_COM_TOGGLE)
      |=> (OC_STATE != $past(OC_STATE)))
    else $error("force did not apply the action");

  chk_cmp_direct: assert property (
    cmp_wr && !pwm |=> (s_r.ocr == $past(PWDATA[7:0])))
    else $error("compare not written directly in non-PWM mode");

  cov_clear_toggle: cover property (
    TIMER_CLK_EN && (s_r.wgm == t8wg_pkg::T8WG_CLEAR_CMP) && hit &&
      (s_r.com == `T8WG_COM_TOGGLE));
  cov_fast_spike: cover property (
    (s_r.wgm == t8wg_pkg::T8WG_FAST) && (s_r.ocr == `T8WG_CNT_BOTTOM) &&
      !OC_STATE ##1 OC_STATE ##[1:20] !OC_STATE);
  cov_block_hit: cover property (
    cnt_wr && (PWDATA[7:0] == s_r.ocr) ##[1:20] TIMER_CLK_EN);
  cov_force: cover property (force_now && (new_com == `T8WG_COM_TOGGLE));

endmodule

// file: tb/t8wg_load.sv
`timescale 1ns/1ps
// A pull-down sits on the pin, so an undriven pin reads low.
module t8wg_load #(
  parameter logic PULL = 1'h0
) (
  input wire logic drv, // value from the block
  input wire logic oe, // driver enable from the block
  output logic lvl // level seen on the wire
);
  assign lvl = oe ? drv : PULL;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "t8wg_cfg.svh"
module tb_top;
  typedef struct packed {
    logic [1:0] wgm, com;
    logic [7:0] cmp, cnt, n, ecnt;
    logic eoc, eovf, ecmp;
  } t8wg_row_t;
  t8wg_row_t rows [8] = '{
    '{2'h0, 2'h0, 8'h10, 8'hFE, 8'h2, 8'h00, 1'h0, 1'h1, 1'h0},
    '{2'h2, 2'h1, 8'h03, 8'h01, 8'h3, 8'h00, 1'h1, 1'h0, 1'h1},
    '{2'h2, 2'h1, 8'h02, 8'hFE, 8'h5, 8'h00, 1'h1, 1'h1, 1'h1},
    '{2'h3, 2'h2, 8'h02, 8'hFE, 8'h4, 8'h02, 1'h1, 1'h1, 1'h0},
    '{2'h3, 2'h2, 8'h02, 8'hFE, 8'h5, 8'h03, 1'h0, 1'h1, 1'h1},
    '{2'h3, 2'h3, 8'h02, 8'hFE, 8'h5, 8'h03, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h0, 8'h01, 8'h00, 8'h2, 8'h00, 1'h0, 1'h0, 1'h1},
    '{2'h2, 2'h1, 8'h05, 8'h05, 8'h1, 8'h06, 1'h0, 1'h0, 1'h0}};
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic timer_en = 1'h0;
  logic ovf_ack = 1'h0;
  logic cmp_ack = 1'h0;
  logic pready, pslverr, pin_o, pin_oe, pin_lvl, oc_state;
  logic ovf_flag, cmp_flag, serr;
  logic [31:0] prdata, rdat;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int hi;

  t8wg_top uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .TIMER_CLK_EN(timer_en), .OVF_ACK(ovf_ack), .CMP_ACK(cmp_ack),
    .PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .OC_STATE(oc_state), .OVF_FLAG(ovf_flag), .CMP_FLAG(cmp_flag));
  t8wg_load load (.drv(pin_o), .oe(pin_oe), .lvl(pin_lvl));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Guards against a handshake that never completes.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic reset();
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [31:0] ctl(logic [1:0] w, c, logic f);
    return {24'h0, f, 2'h0, 1'h0, c, w};
  endfunction

  task automatic tick(input int n);
    @(posedge ref_clk);
    timer_en <= 1'h1;
    repeat (n) @(posedge ref_clk);
    timer_en <= 1'h0;
    #1;
  endtask

  task automatic setup(input logic [7:0] cmp, cnt, input logic [31:0] c);
    reset();
    apb(1'h1, `T8WG_OFF_CMP, {24'h0, cmp});
    apb(1'h1, `T8WG_OFF_CNT, {24'h0, cnt});
    apb(1'h1, `T8WG_OFF_CTRL, c);
  endtask

  task automatic fast_run(input logic [7:0] cmp, input int exp);
    setup(cmp, 8'hFF, ctl(2'h3, 2'h2, 1'h0));
    hi = 0;
    repeat (256) begin
      tick(1);
      if (oc_state === 1'h1) hi++;
    end
    chk(32'(hi), 32'(exp));
  endtask

  initial begin
    reset();
    #1;
    chk(32'(oc_state), 32'h0);
    chk(32'(pin_oe), 32'h0);
    apb(1'h0, `T8WG_OFF_CTRL, 32'h0);
    chk(rdat, 32'h0);
    foreach (rows[i]) begin
      setup(rows[i].cmp, rows[i].cnt, ctl(rows[i].wgm, rows[i].com, 1'h0));
      tick(int'(rows[i].n));
      apb(1'h0, `T8WG_OFF_CNT, 32'h0);
      chk(rdat, {24'h0, rows[i].ecnt});
      chk(32'(oc_state), 32'(rows[i].eoc));
      chk(32'(ovf_flag), 32'(rows[i].eovf));
      chk(32'(cmp_flag), 32'(rows[i].ecmp));
      apb(1'h1, `T8WG_OFF_FLAG, 32'h1);
      @(posedge ref_clk);
      cmp_ack <= 1'h1;
      @(posedge ref_clk);
      cmp_ack <= 1'h0;
      #1;
      chk(32'({ovf_flag, cmp_flag}), 32'h0);
    end
    reset();
    apb(1'h1, `T8WG_OFF_PIN, 32'h2);
    #1;
    chk(32'({pin_oe, pin_o}), 32'h2);
    apb(1'h1, `T8WG_OFF_CTRL, ctl(2'h0, 2'h1, 1'h1));
    #1;
    chk(32'({oc_state, cmp_flag, pin_o}), 32'h5);
    apb(1'h0, `T8WG_OFF_PIN, 32'h0);
    chk(32'(rdat[2]), 32'h1);
    apb(1'h0, `T8WG_OFF_CNT, 32'h0);
    chk(rdat, 32'h0);
    apb(1'h1, `T8WG_OFF_CTRL, ctl(2'h3, 2'h1, 1'h0));
    #1;
    chk(32'(pin_o), 32'h1);
    apb(1'h1, `T8WG_OFF_PIN, 32'h0);
    apb(1'h0, `T8WG_OFF_PIN, 32'h0);
    chk(32'({pin_oe, rdat[2]}), 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk({serr, rdat[30:0]}, 32'h8000_0000);
    fast_run(8'h00, 1);
    fast_run(8'hFF, 256);
    @(posedge ref_clk);
    ovf_ack <= 1'h1;
    @(posedge ref_clk);
    ovf_ack <= 1'h0;
    #1;
    chk(32'(ovf_flag), 32'h0);
    end_of_test();
  end
endmodule
